// ===== acs_pkg.sv
`default_nettype none
package acs_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_ONE_OFF  = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFF  = 8'h04;
  localparam logic [7:0] CHAN_SEL_OFF  = 8'h08;
  localparam logic [7:0] SCAN_SEL_OFF  = 8'h0c;
  localparam logic [7:0] SAMPLE_BIT_TIME_OFF = 8'h10;
  localparam logic [1:0] BUF_REGION    = 2'h1;  // Result words at 0x40..0x7c

  // ****************************************
  // Control register one fields
  // ****************************************
  localparam int C1_ON_BIT    = 15;
  localparam int C1_STOP_IN_IDLE_BIT  = 13;
  localparam int C1_FORM_LSB  = 8;
  localparam int C1_SSRC_LSB  = 5;
  localparam int C1_CLRA_BIT  = 4;
  localparam int C1_AUTO_SAMPLE_BIT  = 2;
  localparam int C1_SAMPLE_BIT_BIT  = 1;
  localparam int C1_DONE_BIT  = 0;

  // ****************************************
  // Control register two fields
  // ****************************************
  localparam int C2_VCFG_LSB  = 13;
  localparam int C2_OFFC_BIT  = 12;
  localparam int C2_SCAN_BIT  = 10;
  localparam int C2_FILL_STATUS_BIT  = 7;
  localparam int C2_SMPI_LSB  = 2;
  localparam int C2_BUFFER_MODE_BIT  = 1;
  localparam int C2_ALTERNATE_INPUT_BIT  = 0;

  // ****************************************
  // Channel select, scan select, sample time fields
  // ****************************************
  localparam int CH_NB_BIT    = 31;
  localparam int CH_SB_LSB    = 24;
  localparam int CH_NA_BIT    = 23;
  localparam int CH_SA_LSB    = 16;
  localparam int SAMC_LSB     = 8;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [2:0] FMT_SFRAC32 = 3'h7;
  localparam logic [2:0] FMT_SINT32  = 3'h5;
  localparam logic [2:0] FMT_INT32   = 3'h4;
  localparam logic [2:0] FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] FMT_FRAC16  = 3'h2;
  localparam logic [2:0] TRG_COUNTER = 3'h7;
  localparam logic [2:0] TRG_CHARGE  = 3'h3;
  localparam logic [2:0] TRG_TIMER3  = 3'h2;
  localparam logic [2:0] TRG_EXTERNAL_INTERRUPT_ZERO    = 3'h1;
  localparam logic [2:0] TRG_MANUAL  = 3'h0;
  localparam logic [2:0] VREF_EXT_P  = 3'h1;
  localparam logic [2:0] VREF_EXT_N  = 3'h2;
  localparam logic [2:0] VREF_EXT_PN = 3'h3;
  localparam logic [4:0] SAMC_RESET  = 5'h00;
  localparam logic [4:0] SAMC_MIN    = 5'h01;
  localparam logic [3:0] HALF_BASE   = 4'h8;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_sample  = 2'b01,
    st_convert = 2'b10
  } acs_state_t;

endpackage
`default_nettype wire

// ===== acs_format.sv
`timescale 1ns/1ps
`default_nettype none
module acs_format
  import acs_pkg::*;
(
  input  wire logic [2:0]  fmt_i,
  input  wire logic [9:0]  data_i,
  output logic      [31:0] word_o
);
  // Signed forms read the unipolar code as offset binary: the sign is the inverted MSB
  always_comb
  begin
    unique case (fmt_i)
      FMT_SFRAC32: word_o = {~data_i[9], data_i[8:0], 22'h000000};
      FMT_SINT32:  word_o = {{22{~data_i[9]}}, ~data_i[9], data_i[8:0]};
      FMT_INT32:   word_o = {22'h000000, data_i};
      FMT_SFRAC16: word_o = {16'h0000, ~data_i[9], data_i[8:0], 6'h00};
      FMT_FRAC16:  word_o = {16'h0000, data_i, 6'h00};
      default:     word_o = {22'h000000, data_i};
    endcase
  end
endmodule // acs_format
`default_nettype wire

// ===== acs_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_top
  import acs_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              idle_mode_i,
  input  wire logic              tad_tick_i,
  input  wire logic              timer3_match_i,
  input  wire logic              charge_trig_i,
  input  wire logic              ext_external_interrupt_zero_i,
  input  wire logic              conv_done_i,
  input  wire logic [9:0]        conv_data_i,
  output logic                   enable_o,
  output logic                   sample_o,
  output logic                   conv_start_o,
  output logic      [3:0]        pos_sel_o,
  output logic                   neg_sel_o,
  output logic                   cal_o,
  output logic                   vref_hi_ext_o,
  output logic                   vref_lo_ext_o,
  output logic                   event_o
);

  // ****************************************
  // Storage
  // ****************************************
  acs_state_t  state_q;
  logic        on_q, stop_in_idle_q, stop_on_first_interrupt_q, auto_sample_q, done_q;
  logic [2:0]  form_q, ssrc_q, vcfg_q;
  logic        offset_calibration_q, scan_q, buffer_mode_q, alternate_input_q, fill_status_q;
  logic [3:0]  smpi_q, seq_cnt_q, wr_ptr_q, scan_ptr_q;
  logic [3:0]  sel_a_q, sel_b_q;
  logic        neg_a_q, neg_b_q, alt_b_q;
  logic [15:0] scan_mask_q;
  logic [4:0]  samc_q, smp_cnt_q;
  logic        external_interrupt_zero_s1_q, external_interrupt_zero_s2_q, external_interrupt_zero_s3_q;
  logic [31:0] buf_q [16];
  logic [31:0] fmt_word;
  logic [31:0] rd_data;
  logic        hit, wr_en, run, fire, conv_end, irq_now;
  logic        wr_c1, wr_c2;
  logic [4:0]  samc_eff;

  // ****************************************
  // APB slave, one wait state on every access
  // ****************************************
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & hit;
  assign wr_c1 = wr_en & (paddr_i[7:0] == CTRL_ONE_OFF);
  assign wr_c2 = wr_en & (paddr_i[7:0] == CTRL_TWO_OFF);

  always_comb
  begin
    rd_data = 32'h00000000;
    hit     = 1'b1;
    if (paddr_i[7:0] == CTRL_ONE_OFF)
    begin
      rd_data[C1_ON_BIT]          = on_q;
      rd_data[C1_STOP_IN_IDLE_BIT]        = stop_in_idle_q;
      rd_data[C1_FORM_LSB +: 3]   = form_q;
      rd_data[C1_SSRC_LSB +: 3]   = ssrc_q;
      rd_data[C1_CLRA_BIT]        = stop_on_first_interrupt_q;
      rd_data[C1_AUTO_SAMPLE_BIT]        = auto_sample_q;
      rd_data[C1_SAMPLE_BIT_BIT]        = state_q[0];
      rd_data[C1_DONE_BIT]        = done_q;
    end
    else if (paddr_i[7:0] == CTRL_TWO_OFF)
    begin
      rd_data[C2_VCFG_LSB +: 3]   = vcfg_q;
      rd_data[C2_OFFC_BIT]        = offset_calibration_q;
      rd_data[C2_SCAN_BIT]        = scan_q;
      rd_data[C2_FILL_STATUS_BIT]        = fill_status_q;
      rd_data[C2_SMPI_LSB +: 4]   = smpi_q;
      rd_data[C2_BUFFER_MODE_BIT]        = buffer_mode_q;
      rd_data[C2_ALTERNATE_INPUT_BIT]        = alternate_input_q;
    end
    else if (paddr_i[7:0] == CHAN_SEL_OFF)
    begin
      rd_data[CH_NB_BIT]          = neg_b_q;
      rd_data[CH_SB_LSB +: 4]     = sel_b_q;
      rd_data[CH_NA_BIT]          = neg_a_q;
      rd_data[CH_SA_LSB +: 4]     = sel_a_q;
    end
    else if (paddr_i[7:0] == SCAN_SEL_OFF)
      rd_data[15:0] = scan_mask_q;
    else if (paddr_i[7:0] == SAMPLE_BIT_TIME_OFF)
      rd_data[SAMC_LSB +: 5] = samc_q;
    else if (paddr_i[7:6] == BUF_REGION && paddr_i[1:0] == 2'h0)
      rd_data = buf_q[paddr_i[5:2]];
    else
      hit = 1'b0;
    // Address bits above the map decode as unmapped; the padding keeps an 8-bit bus legal
    if (({8'h00, paddr_i} >> 8) != '0)
      hit = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= ~hit;
      prdata_o  <= hit ? rd_data : 32'h00000000;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      on_q <= 1'b0;
      stop_in_idle_q <= 1'b0;
      form_q <= 3'h0;
      ssrc_q <= 3'h0;
      stop_on_first_interrupt_q <= 1'b0;
    end
    else if (wr_c1)
    begin
      on_q      <= pwdata_i[C1_ON_BIT];
      stop_in_idle_q    <= pwdata_i[C1_STOP_IN_IDLE_BIT];
      form_q    <= pwdata_i[C1_FORM_LSB +: 3];
      ssrc_q    <= pwdata_i[C1_SSRC_LSB +: 3];
      stop_on_first_interrupt_q <= pwdata_i[C1_CLRA_BIT];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      vcfg_q <= 3'h0;
      offset_calibration_q <= 1'b0;
      scan_q <= 1'b0;
      smpi_q <= 4'h0;
      buffer_mode_q <= 1'b0;
      alternate_input_q <= 1'b0;
      sel_a_q <= 4'h0;
      sel_b_q <= 4'h0;
      neg_a_q <= 1'b0;
      neg_b_q <= 1'b0;
      scan_mask_q <= 16'h0000;
      samc_q <= SAMC_RESET;
    end
    else if (wr_c2)
    begin
      vcfg_q   <= pwdata_i[C2_VCFG_LSB +: 3];
      offset_calibration_q <= pwdata_i[C2_OFFC_BIT];
      scan_q   <= pwdata_i[C2_SCAN_BIT];
      smpi_q   <= pwdata_i[C2_SMPI_LSB +: 4];
      buffer_mode_q   <= pwdata_i[C2_BUFFER_MODE_BIT];
      alternate_input_q   <= pwdata_i[C2_ALTERNATE_INPUT_BIT];
    end
    else if (wr_en && paddr_i[7:0] == CHAN_SEL_OFF)
    begin
      sel_b_q <= pwdata_i[CH_SB_LSB +: 4];
      sel_a_q <= pwdata_i[CH_SA_LSB +: 4];
      neg_b_q <= pwdata_i[CH_NB_BIT];
      neg_a_q <= pwdata_i[CH_NA_BIT];
    end
    else if (wr_en && paddr_i[7:0] == SCAN_SEL_OFF)
      scan_mask_q <= pwdata_i[15:0];
    else if (wr_en && paddr_i[7:0] == SAMPLE_BIT_TIME_OFF)
      samc_q <= pwdata_i[SAMC_LSB +: 5];
  end

  // ****************************************
  // Trigger sources
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      external_interrupt_zero_s1_q <= 1'b0;
      external_interrupt_zero_s2_q <= 1'b0;
      external_interrupt_zero_s3_q <= 1'b0;
    end
    else
    begin
      external_interrupt_zero_s1_q <= ext_external_interrupt_zero_i;
      external_interrupt_zero_s2_q <= external_interrupt_zero_s1_q;
      external_interrupt_zero_s3_q <= external_interrupt_zero_s2_q;
    end
  end

  // A zero sample time is illegal; it is run as one period so sampling cannot hang
  assign samc_eff = (samc_q < SAMC_MIN) ? SAMC_MIN : samc_q;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || state_q != st_sample)
      smp_cnt_q <= 5'h00;
    else if (tad_tick_i && smp_cnt_q != samc_eff)
      smp_cnt_q <= smp_cnt_q + 5'h01;
  end

  always_comb
  begin
    unique case (ssrc_q)
      TRG_COUNTER: fire = (smp_cnt_q == samc_eff);
      TRG_CHARGE:  fire = charge_trig_i;
      TRG_TIMER3:  fire = timer3_match_i;
      TRG_EXTERNAL_INTERRUPT_ZERO:    fire = external_interrupt_zero_s2_q & ~external_interrupt_zero_s3_q;
      TRG_MANUAL:  fire = wr_c1 & ~pwdata_i[C1_SAMPLE_BIT_BIT];
      default:     fire = 1'b0;
    endcase
  end

  // ****************************************
  // Sample and convert sequencer
  // ****************************************
  assign run      = on_q & ~(stop_in_idle_q & idle_mode_i);
  assign conv_end = run & (state_q == st_convert) & conv_done_i;
  assign irq_now  = conv_end & (seq_cnt_q == smpi_q);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !run)
      state_q <= st_idle;
    else
    begin
      unique case (state_q)
        st_idle:
          if (auto_sample_q || (wr_c1 && pwdata_i[C1_SAMPLE_BIT_BIT]))
            state_q <= st_sample;
        st_sample:
          if (fire)
            state_q <= st_convert;
        st_convert:
          if (conv_done_i)
            state_q <= (auto_sample_q && !(irq_now && stop_on_first_interrupt_q)) ? st_sample : st_idle;
        default:
          state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      conv_start_o <= 1'b0;
    else
      conv_start_o <= run & (state_q == st_sample) & fire;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      auto_sample_q <= 1'b0;
    else if (irq_now && stop_on_first_interrupt_q)
      auto_sample_q <= 1'b0;
    else if (wr_c1)
      auto_sample_q <= pwdata_i[C1_AUTO_SAMPLE_BIT];
  end

  // Hardware set wins over a software clear arriving in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      done_q <= 1'b0;
    else if (conv_end)
      done_q <= 1'b1;
    else if (run && state_q == st_sample && fire)
      done_q <= 1'b0;
    else if (wr_c1 && !pwdata_i[C1_DONE_BIT])
      done_q <= 1'b0;
  end

  // ****************************************
  // Sequence pacing and result buffer
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !on_q)
      seq_cnt_q <= 4'h0;
    else if (irq_now)
      seq_cnt_q <= 4'h0;
    else if (conv_end)
      seq_cnt_q <= seq_cnt_q + 4'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      event_o <= 1'b0;
    else
      event_o <= irq_now;
  end

  acs_format u_format (
    .fmt_i  (form_q),
    .data_i (conv_data_i),
    .word_o (fmt_word)
  );

  always_ff @(posedge mclk_i)
  begin
    if (conv_end)
      buf_q[wr_ptr_q] <= fmt_word;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !buffer_mode_q)
      fill_status_q <= 1'b0;
    else if (irq_now)
      fill_status_q <= ~fill_status_q;
  end

  // A split half wraps on itself so a long pacing count never spills into the other half
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !on_q)
      wr_ptr_q <= 4'h0;
    else if (irq_now)
      wr_ptr_q <= (buffer_mode_q && !fill_status_q) ? HALF_BASE : 4'h0;
    else if (conv_end && buffer_mode_q)
      wr_ptr_q <= {wr_ptr_q[3], wr_ptr_q[2:0] + 3'h1};
    else if (conv_end)
      wr_ptr_q <= wr_ptr_q + 4'h1;
  end

  // ****************************************
  // Input selection
  // ****************************************
  function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] idx;
    logic       found;
    next_scan = cur;
    found     = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      idx = cur + i[3:0];
      if (!found && mask[idx])
      begin
        next_scan = idx;
        found     = 1'b1;
      end
    end
  endfunction

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !on_q || irq_now)
      scan_ptr_q <= next_scan(scan_mask_q, 4'hf);
    else if (conv_end)
      scan_ptr_q <= next_scan(scan_mask_q, scan_ptr_q);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !on_q || !alternate_input_q)
      alt_b_q <= 1'b0;
    else if (conv_end)
      alt_b_q <= ~alt_b_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pos_sel_o <= 4'h0;
      neg_sel_o <= 1'b0;
      cal_o <= 1'b0;
      enable_o <= 1'b0;
      vref_hi_ext_o <= 1'b0;
      vref_lo_ext_o <= 1'b0;
    end
    else
    begin
      cal_o     <= offset_calibration_q;
      neg_sel_o <= ~offset_calibration_q & (alt_b_q ? neg_b_q : neg_a_q);
      if (offset_calibration_q)
        pos_sel_o <= 4'h0;
      else if (scan_q)
        pos_sel_o <= scan_ptr_q;
      else
        pos_sel_o <= alt_b_q ? sel_b_q : sel_a_q;
      enable_o      <= run;
      vref_hi_ext_o <= (vcfg_q == VREF_EXT_P) | (vcfg_q == VREF_EXT_PN);
      vref_lo_ext_o <= (vcfg_q == VREF_EXT_N) | (vcfg_q == VREF_EXT_PN);
    end
  end

  assign sample_o = state_q[0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_halt_when_off: assert property (!on_q |=> state_q == st_idle && !enable_o)
    else $error("converter not halted while disabled");
  a_idle_stop: assert property (stop_in_idle_q && idle_mode_i |=> state_q == st_idle)
    else $error("converter ran during idle with stop-in-idle set");
  a_manual_conv: assert property (run && state_q == st_sample && ssrc_q == TRG_MANUAL && wr_c1 && !pwdata_i[C1_SAMPLE_BIT_BIT] |=> conv_start_o && state_q == st_convert)
    else $error("manual clear did not start conversion");
  a_timer_trig: assert property (run && state_q == st_sample && ssrc_q == TRG_TIMER3 && timer3_match_i |=> !sample_o && conv_start_o)
    else $error("timer trigger did not end sampling");
  a_auto_resample: assert property (conv_end && auto_sample_q && !stop_on_first_interrupt_q |=> sample_o)
    else $error("auto-sample did not restart sampling");
  a_done_cycle: assert property (conv_end |=> done_q)
    else $error("done flag not set at conversion end");
  a_done_clear: assert property (conv_start_o |-> !done_q)
    else $error("done flag not cleared at conversion start");
  a_irq_pace: assert property (event_o |-> $past(conv_end) && $past(seq_cnt_q) == $past(smpi_q))
    else $error("interrupt raised off its count");
  a_stop_first: assert property (irq_now && stop_on_first_interrupt_q |=> !auto_sample_q && state_q == st_idle)
    else $error("auto-sample not stopped at first interrupt");
  a_half_swap: assert property (event_o && buffer_mode_q |-> fill_status_q != $past(fill_status_q) && wr_ptr_q[3] == fill_status_q)
    else $error("split buffer did not swap halves");
  a_upper_zero: assert property (pready_o && $past(paddr_i[7:0]) <= CTRL_TWO_OFF |-> prdata_o[31:16] == 16'h0000)
    else $error("upper control bits not zero");
  a_sample_len: assert property (run && state_q == st_sample && ssrc_q == TRG_COUNTER && smp_cnt_q == samc_eff |=> conv_start_o)
    else $error("counter trigger failed to end sampling");
  a_fmt_int32: assert property (form_q == FMT_INT32 |-> fmt_word == {22'h000000, conv_data_i})
    else $error("integer format wrong");
  a_fmt_frac16: assert property (form_q == FMT_FRAC16 |-> fmt_word[31:16] == 16'h0000 && fmt_word[5:0] == 6'h00)
    else $error("fraction format wrong");

  c_manual_conv: cover property (state_q == st_sample ##1 conv_start_o ##[1:50] conv_end);
  c_split_irq: cover property (event_o && buffer_mode_q);
  c_scan_step: cover property (scan_q && conv_end ##1 pos_sel_o != $past(pos_sel_o));

endmodule // acs_top
`default_nettype wire

// ===== acs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Analog core stand-in
// ****************************************
module acs_core_model (
  input  wire logic       mclk_i,
  input  wire logic       start_i,
  input  wire logic [3:0] lat_i,
  input  wire logic [9:0] val_i,
  output logic            done_o,
  output logic      [9:0] data_o
);
  logic [4:0] cnt_q = 5'h00;
  initial done_o = 1'b0;
  initial data_o = 10'h000;
  // Result is only meaningful with done, so the bus keeps toggling otherwise
  always @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i === 1'b1)
      cnt_q <= {1'b0, lat_i} + 5'h01;
    else if (cnt_q == 5'h01)
    begin
      done_o <= 1'b1;
      data_o <= val_i;
      cnt_q  <= 5'h00;
    end
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
endmodule // acs_core_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Converter control bench
// ****************************************
module tb;
  import acs_pkg::*;
  logic mclk_i=0, srst_i=1, psel_i=0, penable_i=0, pwrite_i=0, idle_mode_i=0, tad_tick_i=0;
  logic timer3_match_i=0, charge_trig_i=0, ext_external_interrupt_zero_i=0, conv_done_i, tad_en=0, pslverr_o;
  logic pready_o, enable_o, sample_o, conv_start_o, neg_sel_o, cal_o, event_o, err;
  logic vref_hi_ext_o, vref_lo_ext_o;
  logic [7:0]  paddr_i=0;
  logic [31:0] pwdata_i=0, prdata_o, rd;
  logic [3:0]  pos_sel_o, lat=0;
  logic [9:0]  conv_data_i, val=0;
  int failures=0, n_checks=0, n_ev=0, n_conv=0, ticks=0, e0;
  always #2 mclk_i = ~mclk_i;
  acs_top i_dut (.mclk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .idle_mode_i, .tad_tick_i, .timer3_match_i,
    .charge_trig_i, .ext_external_interrupt_zero_i, .conv_done_i, .conv_data_i, .enable_o, .sample_o,
    .conv_start_o, .pos_sel_o, .neg_sel_o, .cal_o, .vref_hi_ext_o, .vref_lo_ext_o, .event_o);
  acs_core_model i_core (.mclk_i(mclk_i), .start_i(conv_start_o), .lat_i(lat), .val_i(val),
    .done_o(conv_done_i), .data_o(conv_data_i));
  always @(posedge mclk_i)
  begin
    if (event_o === 1'b1) n_ev++;
    if (conv_start_o === 1'b1) n_conv++;
    if (sample_o === 1'b1 && tad_tick_i === 1'b1) ticks++;
    tad_tick_i <= tad_en & ~tad_tick_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_done();
    rd = 0;
    for (int i = 0; i < 30 && rd[0] !== 1'b1; i++) apb(0, CTRL_ONE_OFF, 0);
  endtask
  function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] d);
    case (f)
      3'h7: return {~d[9], d[8:0], 22'h0};
      3'h5: return {{23{~d[9]}}, d[8:0]};
      3'h3: return {16'h0, ~d[9], d[8:0], 6'h0};
      3'h2: return {16'h0, d, 6'h0};
      default: return {22'h0, d};
    endcase
  endfunction
  // One manual conversion, result expected in word idx
  task automatic conv(input logic [2:0] f, input logic [3:0] idx);
    logic [31:0] c;
    c = 32'h8000 | {f, 8'h00};
    val = 10'($urandom);
    lat = 4'($urandom);
    apb(1, CTRL_ONE_OFF, c);
    apb(1, CTRL_ONE_OFF, c | 32'h2);
    @(posedge mclk_i);
    chk({31'h0, sample_o}, 1);
    apb(1, CTRL_ONE_OFF, c);
    wait_done();
    chk(rd, c | 32'h1);
    apb(0, {2'h1, idx, 2'h0}, 0);
    chk(rd, fmt(f, val));
    apb(1, CTRL_ONE_OFF, c);
    apb(0, CTRL_ONE_OFF, 0);
    chk(rd, c);
  endtask
  // Hardware trigger run; a reserved code must leave sampling running
  task automatic trig(input logic [2:0] s);
    apb(1, CTRL_ONE_OFF, 32'h8000 | {s, 5'h00});
    apb(1, CTRL_ONE_OFF, 32'h8002 | {s, 5'h00});
    repeat (3) @(posedge mclk_i);
    chk({31'h0, sample_o}, 1);
    {timer3_match_i, charge_trig_i, ext_external_interrupt_zero_i} <= s[2] ? 3'h7 :
      {s == TRG_TIMER3, s == TRG_CHARGE, s == TRG_EXTERNAL_INTERRUPT_ZERO};
    @(posedge mclk_i);
    {timer3_match_i, charge_trig_i} <= 2'h0;
    wait_done();
    ext_external_interrupt_zero_i <= 1'b0;
    chk(rd, 32'h8000 | {s, 5'h00} | (s[2] ? 32'h2 : 32'h1));
  endtask
  task end_of_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'hf1d9f0f5));
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    apb(0, CTRL_ONE_OFF, 0);
    chk(rd, 0);
    apb(1, CHAN_SEL_OFF, 32'h89050000);
    apb(1, CTRL_TWO_OFF, 32'hffffffff);
    apb(0, CTRL_TWO_OFF, 0);
    chk(rd, 32'hf43f);
    repeat (2) @(posedge mclk_i);
    chk({vref_hi_ext_o, vref_lo_ext_o, cal_o, neg_sel_o, pos_sel_o}, 8'h20);
    for (int v = 0; v < 4; v++)
    begin
      apb(1, CTRL_TWO_OFF, (v << 13) | 1);
      repeat (2) @(posedge mclk_i);
      chk({vref_hi_ext_o, vref_lo_ext_o, cal_o, neg_sel_o, pos_sel_o}, {v[0], v[1], 6'h05});
    end
    apb(0, 8'h14, 0);
    chk({31'h0, err}, 1);
    chk(rd, 0);
    chk({31'h0, enable_o}, 0);
    apb(1, CTRL_ONE_OFF, 32'ha000);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, enable_o}, 1);
    idle_mode_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({31'h0, enable_o}, 0);
    apb(1, CTRL_ONE_OFF, 32'h8000);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, enable_o}, 1);
    idle_mode_i <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      conv(i < 8 ? 3'(i) : 3'($urandom), 0);
      chk({27'h0, neg_sel_o, pos_sel_o}, i[0] ? 32'h05 : 32'h19);
    end
    chk(n_ev, n_conv);
    e0 = n_ev;
    apb(1, CTRL_TWO_OFF, 32'h4);
    conv(3'h0, 0);
    conv(3'h4, 1);
    chk(n_ev - e0, 1);
    apb(1, CTRL_TWO_OFF, 0);
    apb(1, SAMPLE_BIT_TIME_OFF, 32'h300);
    apb(1, CTRL_ONE_OFF, 32'h80e0);
    tad_en <= 1'b1;
    apb(1, CTRL_ONE_OFF, 32'h80e2);
    for (int i = 0; i < 40 && conv_start_o !== 1'b1; i++) @(posedge mclk_i);
    chk(ticks, 3);
    wait_done();
    chk(rd, 32'h80e1);
    tad_en <= 1'b0;
    apb(1, CTRL_ONE_OFF, 32'h8000);
    apb(1, CTRL_ONE_OFF, 32'h8002);
    apb(1, CTRL_ONE_OFF, 32'h8004);
    wait_done();
    chk(rd, 32'h8007);
    apb(1, CTRL_ONE_OFF, 32'h8014);
    wait_done();
    chk(rd & 32'h15, 32'h11);
    trig(TRG_TIMER3);
    trig(TRG_EXTERNAL_INTERRUPT_ZERO);
    trig(TRG_CHARGE);
    trig(3'h5);
    apb(1, CTRL_ONE_OFF, 0);
    @(posedge mclk_i);
    apb(1, SCAN_SEL_OFF, 32'h24);
    apb(1, CTRL_TWO_OFF, 32'h406);
    conv(3'h4, 0);
    chk({28'h0, pos_sel_o}, 5);
    conv(3'h4, 1);
    chk({28'h0, pos_sel_o}, 2);
    apb(0, CTRL_TWO_OFF, 0);
    chk(rd, 32'h486);
    conv(3'h4, 8);
    apb(1, CTRL_ONE_OFF, 0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
